// *** hdl/clock_status_pins.sv ***
// Status outputs, frequency step pins and manual input select of the clock generator.
// Assumes status levels and pins are synchronous to clock_i; analog detectors lie outside.
`timescale 1ns/1ns
module clock_status_pins #(
   parameter int NUM_OUTPUTS = clock_status_pkg::NUM_OUTPUTS,
   parameter int FREQ_W      = clock_status_pkg::FREQ_W
) (
   input  wire logic                                    clock_i,
   input  wire logic                                    resetn_i,
   input  wire logic                                    pll_locked_i,
   input  wire logic [clock_status_pkg::NUM_INPUTS-1:0] input_active_i,
   input  wire logic                                    reference_active_i,
   input  wire logic                                    freq_step_up_i,
   input  wire logic                                    freq_step_down_i,
   input  wire logic [clock_status_pkg::OUT_SEL_W-1:0]  step_output_sel_i,
   input  wire logic [FREQ_W-1:0]                       step_size_i,
   input  wire logic                                    manual_select_mode_i,
   input  wire logic [clock_status_pkg::SEL_W-1:0]      input_select_i,
   output logic                                         pll_unlock_flag_n_o,
   output logic                                         input0_signal_loss_n_o,
   output logic                                         input1_signal_loss_n_o,
   output logic                                         input2_signal_loss_n_o,
   output logic                                         input3_signal_loss_n_o,
   output logic                                         reference_signal_loss_n_o,
   output logic [clock_status_pkg::SEL_W-1:0]           active_input_o,
   output logic [NUM_OUTPUTS*FREQ_W-1:0]                freq_offset_o,
   output logic                                         step_done_o
);

   logic                                     rst_meta_q;
   logic                                     rst_n_q;
   logic                                     up_pulse;
   logic                                     down_pulse;
   clock_status_pkg::step_kind_t             step_kind;
   logic [clock_status_pkg::NUM_INPUTS-1:0]  loss_n_q;
   logic [FREQ_W-1:0]                        offset_q [NUM_OUTPUTS];
   logic                                     checks_live_q;

   // ==========================================================
   // Output select decode
   // Select codes past the last output match nothing, so they step nothing
   function automatic logic targets_output(input logic [clock_status_pkg::OUT_SEL_W-1:0] sel, input int idx);
      return sel == clock_status_pkg::OUT_SEL_W'(idx);
   endfunction

   // ==========================================================
   // Reset release through two flip-flops
   // Only the second flop feeds the design, so release is never metastable
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ==========================================================
   // Status flags, one register per concern
   // Reset value low, so every flag reads as a fault until its first sample
   // Lock flag: high while locked, low while out of lock
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pll_unlock_flag_n_o <= 1'b0;
      end else begin
         pll_unlock_flag_n_o <= pll_locked_i;
      end
   end

   // Per-input loss flags, low when an input goes quiet
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         loss_n_q <= '0;
      end else begin
         loss_n_q <= input_active_i;
      end
   end

   // Reference loss flag, low when the crystal side goes quiet
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reference_signal_loss_n_o <= 1'b0;
      end else begin
         reference_signal_loss_n_o <= reference_active_i;
      end
   end

   assign input0_signal_loss_n_o = loss_n_q[0];
   assign input1_signal_loss_n_o = loss_n_q[1];
   assign input2_signal_loss_n_o = loss_n_q[2];
   assign input3_signal_loss_n_o = loss_n_q[3];

   // ==========================================================
   // Manual input select; held value otherwise
   // Leaving manual mode keeps the last pin choice
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         active_input_o <= clock_status_pkg::SEL_RESET;
      end else if (manual_select_mode_i) begin
         active_input_o <= input_select_i;
      end
   end

   // ==========================================================
   // Step pin edges, one step per pulse
   // Edge history resets low, the idle level of the pulled-down pins
   step_edge_detect u_step_edge_detect_up (
      .clock_i (clock_i),
      .rst_n_i (rst_n_q),
      .level_i (freq_step_up_i),
      .pulse_o (up_pulse)
   );

   step_edge_detect u_step_edge_detect_down (
      .clock_i (clock_i),
      .rst_n_i (rst_n_q),
      .level_i (freq_step_down_i),
      .pulse_o (down_pulse)
   );

   // Simultaneous up and down cancel out
   always_comb begin
      unique case ({down_pulse, up_pulse})
         2'b01:   step_kind = clock_status_pkg::STEP_UP;
         2'b10:   step_kind = clock_status_pkg::STEP_DOWN;
         default: step_kind = clock_status_pkg::STEP_NONE;
      endcase
   end

   // ==========================================================
   // Per-output frequency offset accumulators
   // Offsets are two's complement and wrap at the register width
   for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      always_ff @(posedge clock_i or negedge rst_n_q) begin
         if (!rst_n_q) begin
            offset_q[g] <= clock_status_pkg::FREQ_RESET[FREQ_W-1:0];
         end else if (targets_output(step_output_sel_i, g)) begin
            if (step_kind == clock_status_pkg::STEP_UP) begin
               offset_q[g] <= offset_q[g] + step_size_i;
            end else if (step_kind == clock_status_pkg::STEP_DOWN) begin
               offset_q[g] <= offset_q[g] - step_size_i;
            end
         end
      end
      assign freq_offset_o[g*FREQ_W +: FREQ_W] = offset_q[g];
   end

   // Step acknowledge pulse
   // Also pulses for a select past the last output, which steps nothing
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         step_done_o <= 1'b0;
      end else begin
         step_done_o <= (step_kind != clock_status_pkg::STEP_NONE);
      end
   end

   // ==========================================================
   // Checks
   // Clocked on clock_i and cut off while the internal reset is low
   // Level checks start one edge after reset ends, once each flag holds a real sample
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         checks_live_q <= 1'b0;
      end else begin
         checks_live_q <= 1'b1;
      end
   end

   a_unlock_follows_lock: assert property (@(posedge clock_i) disable iff (!checks_live_q)
      pll_unlock_flag_n_o == $past(pll_locked_i)) else $error("unlock flag wrong");
   a_input_loss_follows: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      !$past(input_active_i[0]) |-> !input0_signal_loss_n_o) else $error("input loss missed");
   a_ref_loss_follows: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      !$past(reference_active_i) |-> !reference_signal_loss_n_o) else $error("ref loss missed");
   a_step_up_adds: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (step_kind == clock_status_pkg::STEP_UP && step_output_sel_i == 4'h0)
      |=> offset_q[0] == $past(offset_q[0]) + $past(step_size_i)) else $error("step up wrong");
   a_step_down_subs: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (step_kind == clock_status_pkg::STEP_DOWN && step_output_sel_i == 4'h0)
      |=> offset_q[0] == $past(offset_q[0]) - $past(step_size_i)) else $error("step down wrong");
   a_unselected_holds: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      step_output_sel_i != 4'h1 |=> offset_q[1] == $past(offset_q[1])) else $error("wrong output stepped");
   a_manual_select: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      manual_select_mode_i |=> active_input_o == $past(input_select_i)) else $error("select wrong");
   a_one_step_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      freq_step_up_i [*2] |-> !up_pulse) else $error("held pin stepped twice");

   // Every loss flag follows its own input in both directions
   for (genvar c = 0; c < clock_status_pkg::NUM_INPUTS; c++) begin : g_loss_chk
      a_loss_level_each: assert property (@(posedge clock_i) disable iff (!checks_live_q)
         loss_n_q[c] == $past(input_active_i[c])) else $error("input loss flag wrong");
   end
   a_ref_loss_level: assert property (@(posedge clock_i) disable iff (!checks_live_q)
      reference_signal_loss_n_o == $past(reference_active_i)) else $error("reference flag wrong");
   a_select_holds: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      !manual_select_mode_i |=> $stable(active_input_o)) else $error("select moved in auto mode");

   // Each accumulator moves by the configured size only when it is the target
   for (genvar k = 0; k < NUM_OUTPUTS; k++) begin : g_offset_chk
      a_target_steps_up: assert property (@(posedge clock_i) disable iff (!rst_n_q)
         (step_kind == clock_status_pkg::STEP_UP && step_output_sel_i == 4'(k))
         |=> offset_q[k] == $past(offset_q[k]) + $past(step_size_i)) else $error("output step up wrong");
      a_target_steps_down: assert property (@(posedge clock_i) disable iff (!rst_n_q)
         (step_kind == clock_status_pkg::STEP_DOWN && step_output_sel_i == 4'(k))
         |=> offset_q[k] == $past(offset_q[k]) - $past(step_size_i)) else $error("output step down wrong");
      a_other_holds: assert property (@(posedge clock_i) disable iff (!rst_n_q)
         step_output_sel_i != 4'(k) |=> $stable(offset_q[k])) else $error("untargeted output moved");
   end

   // ==========================================================
   // Acknowledge and pulse checks
   a_cancel_holds: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (up_pulse && down_pulse) |=> $stable(offset_q[0]) && !step_done_o) else $error("cancelled pair stepped");
   a_done_on_step: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (up_pulse ^ down_pulse) |=> step_done_o) else $error("step not acknowledged");
   a_done_needs_step: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      !(up_pulse ^ down_pulse) |=> !step_done_o) else $error("acknowledge without step");
   a_one_down_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      freq_step_down_i [*2] |-> !down_pulse) else $error("held down pin stepped twice");

endmodule // clock_status_pins

// *** hdl/clock_status_pkg.sv ***
// Constants shared by the clock status and frequency step pin logic.
// Assumes one 20 MHz clock and pins synchronous to it.
// How it works
// - The unlock flag output is high while the PLL is locked and low while it is out of lock.
// - Each of the four clock inputs has its own active-low loss output that goes low when that input loses activity.
// - The reference loss output goes low when the crystal or oscillator reference loses its signal.
// - A step-up pulse raises the selected output frequency by one configured step.
// - A step-down pulse lowers the selected output frequency by one configured step.
// - The stepped output and the step size come from configuration inputs, not fixed values.
// - In manual pin mode the active input is picked from the two select pins.
package clock_status_pkg;

   // ==========================================================
   // Sizes and reset values
   localparam int          NUM_INPUTS    = 4;
   localparam int          NUM_OUTPUTS   = 12;
   localparam int          SEL_W         = 2;
   localparam int          OUT_SEL_W     = 4;
   localparam int          FREQ_W        = 32;
   localparam logic [1:0]  SEL_RESET     = 2'h0;
   localparam logic [31:0] FREQ_RESET    = 32'h0000_0000;

   // ==========================================================
   // Step request decode
   typedef enum logic [1:0] {
      STEP_NONE = 2'b00,
      STEP_UP   = 2'b01,
      STEP_DOWN = 2'b10
   } step_kind_t;

endpackage

// *** hdl/step_edge_detect.sv ***
// Rising edge detector for one step request pin.
// Assumes the pin is synchronous to clock_i.
`timescale 1ns/1ns
module step_edge_detect (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic level_i,
   output logic      pulse_o
);

   logic level_q;

   // ==========================================================
   // One pulse per low-to-high transition
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_i;
      end
   end

   assign pulse_o = level_i & ~level_q;

endmodule // step_edge_detect

// *** tb/board_ctrl_model.sv ***
// Board control model that drives the frequency step request pins.
// Assumes the device samples the pins on the rising edge of clock_i.
`timescale 1ns/1ns
module board_ctrl_model (
   input  wire logic clock_i,
   output logic      step_up_o,
   output logic      step_down_o
);
   // ==========================================================
   // Pins rest low, like the device's pull-downs
   initial begin
      step_up_o = 1'b0;
      step_down_o = 1'b0;
   end

   // Raise the pins for hold cycles, then leave them low for one cycle
   task automatic pulse(input logic up, input logic dn, input int hold);
      @(negedge clock_i);
      step_up_o = up;
      step_down_o = dn;
      repeat (hold) @(negedge clock_i);
      step_up_o = 1'b0;
      step_down_o = 1'b0;
      @(negedge clock_i);
   endtask
endmodule // board_ctrl_model

// *** tb/clock_status_pins_tb.sv ***
// Self-checking bench for the status, step and input select pins.
// Assumes the design package and the board control model are compiled first.
`timescale 1ns/1ns
module clock_status_pins_tb;
   localparam int NO = clock_status_pkg::NUM_OUTPUTS;
   logic           clock_i = 1'b0, resetn_i = 1'b0, pll_locked_i = 1'b0, reference_active_i = 1'b0;
   logic           manual_select_mode_i = 1'b0, up_w, dn_w, done_w, up, dn;
   logic [3:0]     input_active_i = 4'h0, step_output_sel_i = 4'h0;
   logic [1:0]     input_select_i = 2'h0, exp_sel = 2'h0, act_w;
   logic [31:0]    step_size_i = 32'h0;
   logic [5:0]     flags_w;
   logic [NO*32-1:0] offs_w, exp_offs = '0;
   int             seed = 24, fails = 0, comparisons = 0, done_cnt = 0, exp_done;

   // ==========================================================
   // Clock, done counter and instances; the pulse is counted at the falling edge, where it is settled
   always #25 clock_i = ~clock_i;
   always @(negedge clock_i) if (done_w === 1'b1) done_cnt++;
   board_ctrl_model u_board_ctrl_model (.clock_i(clock_i), .step_up_o(up_w), .step_down_o(dn_w));
   clock_status_pins u_clock_status_pins (.clock_i(clock_i), .resetn_i(resetn_i), .pll_locked_i(pll_locked_i),
      .input_active_i(input_active_i), .reference_active_i(reference_active_i), .freq_step_up_i(up_w),
      .freq_step_down_i(dn_w), .step_output_sel_i(step_output_sel_i), .step_size_i(step_size_i),
      .manual_select_mode_i(manual_select_mode_i), .input_select_i(input_select_i),
      .pll_unlock_flag_n_o(flags_w[5]), .input3_signal_loss_n_o(flags_w[4]), .input2_signal_loss_n_o(flags_w[3]),
      .input1_signal_loss_n_o(flags_w[2]), .input0_signal_loss_n_o(flags_w[1]),
      .reference_signal_loss_n_o(flags_w[0]), .active_input_o(act_w), .freq_offset_o(offs_w), .step_done_o(done_w));

   // ==========================================================
   // Expected offset after one request on the step pins; a pair cancels
   function automatic logic [31:0] next_offset(input logic [31:0] old, input logic [31:0] size,
                                               input logic up_req, input logic dn_req);
      if (up_req && !dn_req) return old + size;
      if (dn_req && !up_req) return old - size;
      return old;
   endfunction

   // Compare tasks and verdict
   task automatic check_done(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %0d step acknowledges, want %0d", $time, got, exp);
      end
   endtask
   task automatic check_pins(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: pins %h, want %h", $time, got, exp);
      end
   endtask
   task automatic check_offs(input logic [NO*32-1:0] got, input logic [NO*32-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: offsets differ", $time);
      end
   endtask
   task automatic complete_run();
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // Reset, then random status levels and step pulses
   initial begin
      repeat (10) @(negedge clock_i);
      check_pins({flags_w, act_w}, 8'h00);
      check_offs(offs_w, '0);
      resetn_i = 1'b1;
      repeat (3) @(negedge clock_i);
      for (int i = 0; i < 60; i++) begin
         {pll_locked_i, input_active_i, reference_active_i} = 6'($random(seed));
         {manual_select_mode_i, input_select_i} = 3'($random(seed));
         if (manual_select_mode_i) exp_sel = input_select_i;
         @(negedge clock_i);
         check_pins({flags_w, act_w}, {pll_locked_i, input_active_i, reference_active_i, exp_sel});
         step_output_sel_i = 4'($unsigned($random(seed)) % 14);
         step_size_i = (i == 1) ? 32'hffff_ffff : 32'($random(seed));
         up = 1'($random(seed));
         dn = (i % 7 == 0) | ~up;
         exp_done = (up ^ dn) ? 1 : 0;
         if (step_output_sel_i < NO) begin
            exp_offs[step_output_sel_i*32 +: 32] =
               next_offset(exp_offs[step_output_sel_i*32 +: 32], step_size_i, up, dn);
         end
         done_cnt = 0;
         u_board_ctrl_model.pulse(up, dn, 1 + i % 3);
         repeat (2) @(negedge clock_i);
         check_offs(offs_w, exp_offs);
         check_done(8'(done_cnt), 8'(exp_done));
      end
      // Hand-written corners: two steps in a row on output 0, then a cancelled pair
      step_output_sel_i = 4'h0;
      step_size_i = 32'h0000_0005;
      done_cnt = 0;
      u_board_ctrl_model.pulse(1'b1, 1'b0, 1);
      u_board_ctrl_model.pulse(1'b1, 1'b0, 1);
      exp_offs[31:0] = next_offset(next_offset(exp_offs[31:0], step_size_i, 1'b1, 1'b0), step_size_i, 1'b1, 1'b0);
      repeat (2) @(negedge clock_i);
      check_offs(offs_w, exp_offs);
      check_done(8'(done_cnt), 8'h02);
      done_cnt = 0;
      u_board_ctrl_model.pulse(1'b1, 1'b1, 2);
      repeat (2) @(negedge clock_i);
      check_offs(offs_w, exp_offs);
      check_done(8'(done_cnt), 8'h00);
      complete_run();
   end
endmodule // clock_status_pins_tb
